// ---- trail_ext_consts.svh ----
// Constants for the chip select trailing extension block.
`ifndef TRAIL_EXT_CONSTS_SVH
`define TRAIL_EXT_CONSTS_SVH
`define TE_AREAS        8
`define TE_AREA_W       3
`define TE_ADDR_W       24
`define TE_OFS_CTRL     8'h00
`define TE_OFS_STATUS   8'h04
`define TE_CTRL_RST     8'h00
`define TE_RESP_OKAY    2'b00
`define TE_RESP_SLVERR  2'b10
`define TE_ACC_STATES   2'h2
`define TE_CNT_ZERO     2'h0
`define TE_ADDR_ZERO    24'h00_0000
`endif

// ---- trail_ext_pkg.sv ----
// Types shared by the chip select trailing extension block.
package trail_ext_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ACC   = 4'b0010,
      ST_TRAIL = 4'b0100,
      ST_DONE  = 4'b1000
   } bus_state_e;
endpackage

// ---- trail_ext_regs.sv ----
// AXI4-Lite slave holding the trailing extension enable register.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "trail_ext_consts.svh"
module trail_ext_regs (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  awaddr_in,
   input  wire logic        awvalid_in,
   output logic             awready_out,
   input  wire logic [31:0] wdata_in,
   input  wire logic [3:0]  wstrb_in,
   input  wire logic        wvalid_in,
   output logic             wready_out,
   output logic [1:0]       bresp_out,
   output logic             bvalid_out,
   input  wire logic        bready_in,
   input  wire logic [7:0]  araddr_in,
   input  wire logic        arvalid_in,
   output logic             arready_out,
   output logic [31:0]      rdata_out,
   output logic [1:0]       rresp_out,
   output logic             rvalid_out,
   input  wire logic        rready_in,
   input  wire logic [7:0]  status_in,
   output logic [7:0]       ctrl_out
);
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw;
      logic        w_got;
      logic [31:0] w;
      logic [3:0]  strb;
      logic        bv;
      logic [1:0]  br;
      logic        rv;
      logic [1:0]  rr;
      logic [31:0] rd;
      logic [7:0]  ctrl;
   } regs_s;
   regs_s q, d;

   // Word decode shared by the write and read paths.
   function automatic logic ofs_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
      ofs_hit = (a[7:2] == ofs[7:2]);
   endfunction

   assign awready_out = !q.aw_got && !q.bv;
   assign wready_out  = !q.w_got && !q.bv;
   assign arready_out = !q.rv;
   assign bvalid_out  = q.bv;
   assign bresp_out   = q.br;
   assign rvalid_out  = q.rv;
   assign rresp_out   = q.rr;
   assign rdata_out   = q.rd;
   assign ctrl_out    = q.ctrl;

   always_comb begin
      d = q;
      if (awvalid_in && awready_out) begin
         d.aw_got = 1'b1;
         d.aw     = awaddr_in;
      end
      if (wvalid_in && wready_out) begin
         d.w_got = 1'b1;
         d.w     = wdata_in;
         d.strb  = wstrb_in;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bv     = 1'b1;
         d.br     = `TE_RESP_OKAY;
         // RQ5 enables writable
         if (ofs_hit(q.aw, `TE_OFS_CTRL)) begin
            if (q.strb[0]) begin
               d.ctrl = q.w[7:0];
            end
         end else if (!ofs_hit(q.aw, `TE_OFS_STATUS)) begin
            d.br = `TE_RESP_SLVERR;
         end
      end
      if (q.bv && bready_in) begin
         d.bv = 1'b0;
      end
      if (q.rv && rready_in) begin
         d.rv = 1'b0;
      end
      if (arvalid_in && arready_out) begin
         d.rv = 1'b1;
         d.rr = `TE_RESP_OKAY;
         d.rd = 32'h0000_0000;
         // RQ5 enables readable
         if (ofs_hit(araddr_in, `TE_OFS_CTRL)) begin
            d.rd[7:0] = q.ctrl;
         end else if (ofs_hit(araddr_in, `TE_OFS_STATUS)) begin
            d.rd[7:0] = status_in;
         end else begin
            d.rr = `TE_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         // RQ5 reset zero
         q <= '{default: '0};
      end else begin
         q <= d;
      end
   end
endmodule

// ---- trail_ext_seq.sv ----
// Bus cycle sequencer with an optional trailing hold state.
`timescale 1ns/1ps
`include "trail_ext_consts.svh"
module trail_ext_seq #(
   parameter int ADDR_W = `TE_ADDR_W
) (
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic [7:0]            trail_ext_enable_area_in,
   input  wire logic                  req_valid_in,
   output logic                       req_ready_out,
   input  wire logic [`TE_AREA_W-1:0] req_area_in,
   input  wire logic [ADDR_W-1:0]     req_addr_in,
   input  wire logic                  req_write_in,
   output logic [7:0]                 area_chip_select_n_out,
   output logic [ADDR_W-1:0]          addr_out,
   output logic                       rd_n_out,
   output logic                       wr_n_out,
   output logic                       trailing_hold_state_out,
   output logic                       done_out,
   output logic [7:0]                 status_out
);
   typedef struct packed {
      trail_ext_pkg::bus_state_e st;
      logic [1:0]                cnt;
      logic [`TE_AREA_W-1:0]     area;
      logic [ADDR_W-1:0]         addr;
      logic                      wr;
      logic                      ext;
   } seq_s;
   seq_s q, d;

   function automatic logic [7:0] area_onehot(input logic [2:0] a);
      area_onehot = 8'h01 << a;
   endfunction

   // RQ6 no overlap
   assign req_ready_out = (q.st == trail_ext_pkg::ST_IDLE);
   assign done_out      = (q.st == trail_ext_pkg::ST_DONE);
   assign trailing_hold_state_out = (q.st == trail_ext_pkg::ST_TRAIL);
   assign addr_out      = q.addr;
   assign status_out    = {4'h0, q.st};

   always_comb begin
      area_chip_select_n_out = 8'hFF;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      if (q.st == trail_ext_pkg::ST_ACC) begin
         area_chip_select_n_out = ~area_onehot(q.area);
         rd_n_out = q.wr;
         wr_n_out = !q.wr;
      end
      // RQ3 only select held
      if (q.st == trail_ext_pkg::ST_TRAIL) begin
         area_chip_select_n_out = ~area_onehot(q.area);
      end
   end

   always_comb begin
      d = q;
      case (q.st)
         trail_ext_pkg::ST_IDLE: begin
            if (req_valid_in) begin
               d.st   = trail_ext_pkg::ST_ACC;
               d.cnt  = `TE_CNT_ZERO;
               d.area = req_area_in;
               d.addr = req_addr_in;
               d.wr   = req_write_in;
               // RQ1 per area bit
               d.ext  = trail_ext_enable_area_in[req_area_in];
            end
         end
         trail_ext_pkg::ST_ACC: begin
            d.cnt = q.cnt + 2'h1;
            if (q.cnt == `TE_ACC_STATES - 2'h1) begin
               // RQ2 append one state
               // RQ4 no extension
               d.st = q.ext ? trail_ext_pkg::ST_TRAIL
                            : trail_ext_pkg::ST_DONE;
            end
         end
         trail_ext_pkg::ST_TRAIL: begin
            d.st = trail_ext_pkg::ST_DONE;
         end
         trail_ext_pkg::ST_DONE: begin
            d.st = trail_ext_pkg::ST_IDLE;
         end
         default: begin
            d.st = trail_ext_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q <= '{st: trail_ext_pkg::ST_IDLE, cnt: `TE_CNT_ZERO,
                area: '0, addr: '0, wr: 1'b0, ext: 1'b0};
      end else begin
         q <= d;
      end
   end
endmodule

// ---- chip_select_trailing_extension.sv ----
// Top of the chip select trailing extension block.
`timescale 1ns/1ps
`include "trail_ext_consts.svh"
// Function
// RQ1 - Eight enable bits, one per area 7 to 0, each governs only its area.
// RQ2 - With an area bit set, one extra state follows the normal access.
// RQ3 - In that extra state only chip select and address stay asserted.
// RQ4 - With an area bit clear, the access ends with the normal cycle.
// RQ5 - All enable bits are software read/write and reset to zero.
// RQ6 - The extra state adds one clock and the next cycle waits for it.
module chip_select_trailing_extension #(
   parameter int ADDR_W = `TE_ADDR_W
) (
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic [7:0]            s_axi_awaddr_in,
   input  wire logic                  s_axi_awvalid_in,
   output logic                       s_axi_awready_out,
   input  wire logic [31:0]           s_axi_wdata_in,
   input  wire logic [3:0]            s_axi_wstrb_in,
   input  wire logic                  s_axi_wvalid_in,
   output logic                       s_axi_wready_out,
   output logic [1:0]                 s_axi_bresp_out,
   output logic                       s_axi_bvalid_out,
   input  wire logic                  s_axi_bready_in,
   input  wire logic [7:0]            s_axi_araddr_in,
   input  wire logic                  s_axi_arvalid_in,
   output logic                       s_axi_arready_out,
   output logic [31:0]                s_axi_rdata_out,
   output logic [1:0]                 s_axi_rresp_out,
   output logic                       s_axi_rvalid_out,
   input  wire logic                  s_axi_rready_in,
   input  wire logic                  req_valid_in,
   output logic                       req_ready_out,
   input  wire logic [`TE_AREA_W-1:0] req_area_in,
   input  wire logic [ADDR_W-1:0]     req_addr_in,
   input  wire logic                  req_write_in,
   output logic [7:0]                 area_chip_select_n_out,
   output logic [ADDR_W-1:0]          addr_out,
   output logic                       rd_n_out,
   output logic                       wr_n_out,
   output logic                       trailing_hold_state_out,
   output logic                       done_out
);
   logic [7:0] cs_addr_trailing_ext_ctrl;
   logic [7:0] status;

   trail_ext_regs u_regs (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .awaddr_in   (s_axi_awaddr_in),
      .awvalid_in  (s_axi_awvalid_in),
      .awready_out (s_axi_awready_out),
      .wdata_in    (s_axi_wdata_in),
      .wstrb_in    (s_axi_wstrb_in),
      .wvalid_in   (s_axi_wvalid_in),
      .wready_out  (s_axi_wready_out),
      .bresp_out   (s_axi_bresp_out),
      .bvalid_out  (s_axi_bvalid_out),
      .bready_in   (s_axi_bready_in),
      .araddr_in   (s_axi_araddr_in),
      .arvalid_in  (s_axi_arvalid_in),
      .arready_out (s_axi_arready_out),
      .rdata_out   (s_axi_rdata_out),
      .rresp_out   (s_axi_rresp_out),
      .rvalid_out  (s_axi_rvalid_out),
      .rready_in   (s_axi_rready_in),
      .status_in   (status),
      .ctrl_out    (cs_addr_trailing_ext_ctrl)
   );

   // Accesses latch the enable bit at start, so a write mid-access
   // only affects the following access.
   trail_ext_seq #(
      .ADDR_W (ADDR_W)
   ) u_seq (
      .clk_in                   (clk_in),
      .sys_rst_in               (sys_rst_in),
      .trail_ext_enable_area_in (cs_addr_trailing_ext_ctrl),
      .req_valid_in             (req_valid_in),
      .req_ready_out            (req_ready_out),
      .req_area_in              (req_area_in),
      .req_addr_in              (req_addr_in),
      .req_write_in             (req_write_in),
      .area_chip_select_n_out   (area_chip_select_n_out),
      .addr_out                 (addr_out),
      .rd_n_out                 (rd_n_out),
      .wr_n_out                 (wr_n_out),
      .trailing_hold_state_out  (trailing_hold_state_out),
      .done_out                 (done_out),
      .status_out               (status)
   );
endmodule

// ---- trail_ext_assertions.sv ----
// Checker for the access sequencer of the trailing extension block.
`timescale 1ns/1ps
`include "trail_ext_consts.svh"
module trail_ext_assertions #(
   parameter int ADDR_W = `TE_ADDR_W
) (
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic                  req_valid_in,
   input  wire logic                  req_ready_out,
   input  wire logic [`TE_AREA_W-1:0] req_area_in,
   input  wire logic                  req_write_in,
   input  wire logic [7:0]            area_chip_select_n_out,
   input  wire logic [ADDR_W-1:0]     addr_out,
   input  wire logic                  rd_n_out,
   input  wire logic                  wr_n_out,
   input  wire logic                  trailing_hold_state_out,
   input  wire logic                  done_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire logic take = req_valid_in && req_ready_out;
   wire logic sel = area_chip_select_n_out != 8'hff;
   property p_one_cs; $onehot0(~area_chip_select_n_out); endproperty
   a_one_cs: assert property (p_one_cs)
      else $error("more than one chip select low");
   property p_area;
      take |=> area_chip_select_n_out == ~(8'h01 << $past(req_area_in));
   endproperty
   a_area: assert property (p_area)
      else $error("wrong area selected");
   sequence s_strobes; (!rd_n_out || !wr_n_out) [*2]; endsequence
   property p_len;
      take |=> s_strobes ##1 (done_out || trailing_hold_state_out);
   endproperty
   a_len: assert property (p_len)
      else $error("access length wrong");
   property p_dir;
      take |=> wr_n_out == !$past(req_write_in)
         && rd_n_out == $past(req_write_in);
   endproperty
   a_dir: assert property (p_dir)
      else $error("wrong strobe for direction");
   property p_trail_only;
      trailing_hold_state_out |-> rd_n_out && wr_n_out && sel;
   endproperty
   a_trail_only: assert property (p_trail_only)
      else $error("strobe active in trailing state");
   property p_trail_hold;
      trailing_hold_state_out |-> $stable(area_chip_select_n_out)
         && $stable(addr_out);
   endproperty
   a_trail_hold: assert property (p_trail_hold)
      else $error("select or address moved in trailing state");
   property p_trail_done;
      trailing_hold_state_out |=> done_out && !trailing_hold_state_out;
   endproperty
   a_trail_done: assert property (p_trail_done)
      else $error("trailing state not one cycle");
   property p_busy; sel || done_out |-> !req_ready_out; endproperty
   a_busy: assert property (p_busy)
      else $error("request accepted while busy");
   c_trail: cover property (trailing_hold_state_out);
   c_write: cover property (take && req_write_in);
   c_plain: cover property (done_out && !$past(trailing_hold_state_out));
endmodule

// ---- ext_dev_model.sv ----
// Model of an external device watching chip selects and strobes.
`timescale 1ns/1ps
module ext_dev_model (
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [7:0] cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   output logic [7:0]      hold_cnt_out,
   output logic [7:0]      strobe_cnt_out,
   output logic [7:0]      last_cs_n_out
);
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hold_cnt_out   <= 8'h00;
         strobe_cnt_out <= 8'h00;
         last_cs_n_out  <= 8'hff;
      end else if (cs_n_in != 8'hff) begin
         last_cs_n_out <= cs_n_in;
         if (rd_n_in && wr_n_in)
            hold_cnt_out <= hold_cnt_out + 8'h01;
         else
            strobe_cnt_out <= strobe_cnt_out + 8'h01;
      end
   end
endmodule

// ---- tb.sv ----
// Self-checking testbench of the trailing extension block.
`timescale 1ns/1ps
`include "trail_ext_consts.svh"
module tb;
   logic        clk_in, sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in;
   logic        s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
   logic        req_valid_in, req_write_in, s_axi_awready_out;
   logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic        s_axi_rvalid_out, req_ready_out, rd_n_out, wr_n_out;
   logic        trailing_hold_state_out, done_out;
   logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, area_chip_select_n_out;
   logic [7:0]  hold_cnt, strobe_cnt, last_cs_n;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [3:0]  s_axi_wstrb_in;
   logic [2:0]  req_area_in;
   logic [23:0] req_addr_in, addr_out;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
   int          fail_count, checks_done;
   chip_select_trailing_extension chip_select_trailing_extension_i (
      .clk_in, .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
      .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
      .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
      .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
      .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
      .req_valid_in, .req_ready_out, .req_area_in, .req_addr_in,
      .req_write_in, .area_chip_select_n_out, .addr_out, .rd_n_out,
      .wr_n_out, .trailing_hold_state_out, .done_out);
   ext_dev_model ext_dev_model_i (.clk_in, .sys_rst_in,
      .cs_n_in(area_chip_select_n_out), .rd_n_in(rd_n_out),
      .wr_n_in(wr_n_out), .hold_cnt_out(hold_cnt),
      .strobe_cnt_out(strobe_cnt), .last_cs_n_out(last_cs_n));
   always #10 clk_in = ~clk_in;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ga, gw;
      ga = 1'b0;
      gw = 1'b0;
      s_axi_awaddr_in  <= a;
      s_axi_wdata_in   <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in  <= 1'b1;
      while (!(ga && gw)) begin
         @(posedge clk_in);
         if (!ga && s_axi_awready_out) begin
            ga = 1'b1;
            s_axi_awvalid_in <= 1'b0;
         end
         if (!gw && s_axi_wready_out) begin
            gw = 1'b1;
            s_axi_wvalid_in <= 1'b0;
         end
      end
      do @(posedge clk_in); while (!s_axi_bvalid_out);
      r = s_axi_bresp_out;
   endtask
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr_in  <= a;
      s_axi_arvalid_in <= 1'b1;
      do @(posedge clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      do @(posedge clk_in); while (!s_axi_rvalid_out);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
   endtask
   task acc(input logic [2:0] a, input logic ext);
      logic [7:0] h0, s0, cs;
      int n;
      h0 = hold_cnt;
      s0 = strobe_cnt;
      cs = ~(8'h01 << a);
      req_valid_in <= 1'b1;
      req_area_in  <= a;
      req_addr_in  <= {21'h15_5aa5, a};
      req_write_in <= a[0];
      do @(posedge clk_in); while (!req_ready_out);
      req_valid_in <= 1'b0;
      // Outputs are read as they stood just before each edge.
      n = 0;
      do begin @(posedge clk_in); n++; end while (!done_out && n < 20);
      chk(n, `TE_ACC_STATES + 1 + ext);
      chk(hold_cnt - h0, ext);
      chk(strobe_cnt - s0, `TE_ACC_STATES);
      chk(last_cs_n, cs);
      chk(addr_out, {21'h15_5aa5, a});
   endtask
   task t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axr(`TE_OFS_CTRL, d, r);
      chk(d, `TE_CTRL_RST);
      axw(`TE_OFS_CTRL, 32'h0000_01a5, r);
      chk(r, `TE_RESP_OKAY);
      axr(`TE_OFS_CTRL, d, r);
      chk(d, 32'h0000_00a5);
      s_axi_wstrb_in <= 4'he;
      axw(`TE_OFS_CTRL, 32'h0000_005a, r);
      s_axi_wstrb_in <= 4'hf;
      axr(`TE_OFS_CTRL, d, r);
      chk(d, 32'h0000_00a5);
      axr(`TE_OFS_STATUS, d, r);
      chk(d, trail_ext_pkg::ST_IDLE);
      axr(8'h08, d, r);
      chk(r, `TE_RESP_SLVERR);
   endtask
   // Patterns a5 and 5a, each the inverse of the other, show that every bit acts alone.
   task t_areas;
      logic [7:0] p;
      logic [1:0] r;
      for (int k = 0; k < 3; k++) begin
         p = (k == 0) ? 8'ha5 : (k == 1) ? 8'h5a : 8'h00;
         axw(`TE_OFS_CTRL, {24'h00_0000, p}, r);
         for (int a = 0; a < `TE_AREAS; a++)
            acc(a[2:0], p[a]);
      end
   endtask
   // A reset in mid-run must clear every enable bit again.
   task t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      axw(`TE_OFS_CTRL, 32'h0000_00ff, r);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk(req_ready_out, 1'b1);
      chk(area_chip_select_n_out, 8'hff);
      sys_rst_in <= 1'b0;
      axr(`TE_OFS_CTRL, d, r);
      chk(d, `TE_CTRL_RST);
      acc(3'h5, 1'b0);
   endtask
   initial begin
      {clk_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 4'h0;
      {req_valid_in, req_write_in, req_area_in, req_addr_in} = 29'h0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
      s_axi_bready_in = 1'b1;
      s_axi_rready_in = 1'b1;
      s_axi_wstrb_in  = 4'hf;
      sys_rst_in      = 1'b1;
      fail_count      = 0;
      checks_done     = 0;
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_regs;
      t_areas;
      t_reset;
      print_verdict;
   end
   initial begin
      #200000;
      fail_count++;
      print_verdict;
   end
endmodule
bind chip_select_trailing_extension trail_ext_assertions #(
   .ADDR_W(ADDR_W)) trail_ext_assertions_i (.clk_in, .sys_rst_in,
   .req_valid_in, .req_ready_out, .req_area_in, .req_write_in,
   .area_chip_select_n_out, .addr_out, .rd_n_out, .wr_n_out,
   .trailing_hold_state_out, .done_out);
